// file: rtl/mmu_system_control_regs.sv
// system control coprocessor registers 2 to 13: table base, domains,
// fault capture, cache and tlb commands, relocation and trace ids.
// assumes the core issues privileged transfers on the core clock.
`timescale 1ns/1ps
`include "mmu_sysctl_regs.svh"

module mmu_system_control_regs
	import mmu_sysctl_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic cp_valid_i,
	input wire cp_req_t cp_req_i,
	input wire fault_t fault_i,
	input wire logic mmu_enable_i,
	input wire logic fetch_i,
	output logic [31:0] rd_data_o,
	output logic rd_valid_o,
	output logic [17:0] table_base_o,
	output logic [31:0] domain_fields_o,
	output logic [6:0] relocation_process_id_o,
	output logic fetch_translate_o,
	output logic [6:0] fetch_pid_o,
	output logic [31:0] trace_process_id_o,
	output logic trace_id_write_notify_o,
	output logic cache_inval_all_o,
	output logic tlb_inval_all_o,
	output logic tlb_inval_single_o,
	output logic [31:0] modified_virtual_address_o,
	output logic [8:0] fault_status_o,
	output logic [31:0] fault_address_o
);

	logic wr, rd, op2_zero, op2_one, crm_tlb;
	logic [17:0] ttb_r, ttb_nxt;
	logic [31:0] dom_r, dom_nxt;
	logic [6:0] pid_r, pid_nxt;
	logic [31:0] trace_r, trace_nxt;
	logic notify_r, notify_nxt;
	logic cache_r, cache_nxt;
	logic tlb_all_r, tlb_all_nxt;
	logic tlb_one_r, tlb_one_nxt;
	logic [31:0] mva_r, mva_nxt;
	logic [31:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic fsr_we, far_we;
	logic [`PREFETCH_DEPTH-1:0] pipe_en_r, pipe_en_nxt;
	logic [6:0] pipe_pid_r [`PREFETCH_DEPTH];
	logic [6:0] pipe_pid_nxt [`PREFETCH_DEPTH];

	assign wr = cp_valid_i && cp_req_i.wr;
	assign rd = cp_valid_i && !cp_req_i.wr;
	assign op2_zero = cp_req_i.op2 == `OP2_ZERO;
	assign op2_one = cp_req_i.op2 == `OP2_ONE;
	assign crm_tlb = cp_req_i.coproc_minor_reg_field == `CRM_C5 || cp_req_i.coproc_minor_reg_field == `CRM_C6 ||
		cp_req_i.coproc_minor_reg_field == `CRM_C7;
	assign fsr_we = wr && cp_req_i.crn == `REG_FAULT_STATUS;
	assign far_we = wr && cp_req_i.crn == `REG_FAULT_ADDRESS;

	// stored registers and command pulses
	always_comb begin
		ttb_nxt = ttb_r;
		dom_nxt = dom_r;
		pid_nxt = pid_r;
		trace_nxt = trace_r;
		mva_nxt = mva_r;
		notify_nxt = 1'b0;
		cache_nxt = 1'b0;
		tlb_all_nxt = 1'b0;
		tlb_one_nxt = 1'b0;
		if (wr) begin
			case (cp_req_i.crn)
				`REG_TTB: begin
					ttb_nxt = cp_req_i.wdata[31:`TTB_LSB];
				end
				`REG_DOMAIN: begin
					dom_nxt = cp_req_i.wdata;
				end
				`REG_CACHE_OPS: begin
					cache_nxt = op2_zero && cp_req_i.coproc_minor_reg_field == `CRM_C7;
				end
				`REG_TLB_OPS: begin
					tlb_all_nxt = op2_zero && crm_tlb;
					tlb_one_nxt = op2_one && crm_tlb;
					if (op2_one && crm_tlb) begin
						mva_nxt = cp_req_i.wdata;
					end
				end
				`REG_PROCESS_ID: begin
					if (op2_zero) begin
						pid_nxt = cp_req_i.wdata[31:`PID_LSB];
					end
					if (op2_one) begin
						trace_nxt = cp_req_i.wdata;
						notify_nxt = 1'b1;
					end
				end
				default: begin
					notify_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ttb_r <= `TTB_RESET;
			dom_r <= `WORD_RESET;
			pid_r <= `PID_RESET;
			trace_r <= `WORD_RESET;
			mva_r <= `WORD_RESET;
			notify_r <= 1'b0;
			cache_r <= 1'b0;
			tlb_all_r <= 1'b0;
			tlb_one_r <= 1'b0;
		end else begin
			ttb_r <= ttb_nxt;
			dom_r <= dom_nxt;
			pid_r <= pid_nxt;
			trace_r <= trace_nxt;
			mva_r <= mva_nxt;
			notify_r <= notify_nxt;
			cache_r <= cache_nxt;
			tlb_all_r <= tlb_all_nxt;
			tlb_one_r <= tlb_one_nxt;
		end
	end

	// read mux; unpredictable bits and write-only registers read zero,
	// so a stray read of 7 or 8 is harmless
	always_comb begin
		rd_valid_nxt = rd;
		rd_data_nxt = rd_data_r;
		if (rd) begin
			case (cp_req_i.crn)
				`REG_TTB: begin
					rd_data_nxt = {ttb_r, 14'h0000};
				end
				`REG_DOMAIN: begin
					rd_data_nxt = dom_r;
				end
				`REG_FAULT_STATUS: begin
					rd_data_nxt = {23'h00_0000, fault_status_o};
				end
				`REG_FAULT_ADDRESS: begin
					rd_data_nxt = fault_address_o;
				end
				`REG_PROCESS_ID: begin
					if (op2_one) begin
						rd_data_nxt = trace_r;
					end else begin
						rd_data_nxt = {pid_r, 25'h000_0000};
					end
				end
				default: begin
					rd_data_nxt = `WORD_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rd_data_r <= `WORD_RESET;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// fetch-side view lags by the prefetch depth: instructions already
	// in flight keep the translation state they were fetched with
	genvar g;
	generate
		for (g = 0; g < `PREFETCH_DEPTH; g++) begin : g_prefetch
			logic en_src;
			logic [6:0] pid_src;
			if (g == 0) begin : g_head
				assign en_src = mmu_enable_i;
				assign pid_src = pid_r;
			end else begin : g_tail
				assign en_src = pipe_en_r[g-1];
				assign pid_src = pipe_pid_r[g-1];
			end
			always_comb begin
				pipe_en_nxt[g] = fetch_i ? en_src : pipe_en_r[g];
				pipe_pid_nxt[g] = fetch_i ? pid_src : pipe_pid_r[g];
			end
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					pipe_en_r[g] <= 1'b0;
					pipe_pid_r[g] <= `PID_RESET;
				end else begin
					pipe_en_r[g] <= pipe_en_nxt[g];
					pipe_pid_r[g] <= pipe_pid_nxt[g];
				end
			end
		end
	endgenerate

	fault_capture u_fault (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.fault_i(fault_i),
		.pid_i(pid_r),
		.fsr_we_i(fsr_we),
		.far_we_i(far_we),
		.wdata_i(cp_req_i.wdata),
		.fault_status_o(fault_status_o),
		.fault_address_o(fault_address_o)
	);

	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign table_base_o = ttb_r;
	assign domain_fields_o = dom_r;
	assign relocation_process_id_o = pid_r;
	assign fetch_translate_o = pipe_en_r[`PREFETCH_DEPTH-1];
	assign fetch_pid_o = pipe_pid_r[`PREFETCH_DEPTH-1];
	assign trace_process_id_o = trace_r;
	assign trace_id_write_notify_o = notify_r;
	assign cache_inval_all_o = cache_r;
	assign tlb_inval_all_o = tlb_all_r;
	assign tlb_inval_single_o = tlb_one_r;
	assign modified_virtual_address_o = mva_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence trace_write_s;
		wr && cp_req_i.crn == 4'hd && cp_req_i.op2 == 3'h1;
	endsequence

	sequence notify_pulse_s;
		notify_r ##1 !notify_r;
	endsequence

	ttb_write_a: assert property (wr && cp_req_i.crn == 4'h2
		|=> table_base_o == $past(cp_req_i.wdata[31:14]))
		else $error("table base not loaded");

	ttb_read_a: assert property (rd && cp_req_i.crn == 4'h2
		|=> rd_valid_o && rd_data_o[31:14] == table_base_o)
		else $error("table base read wrong");

	dom_write_a: assert property (wr && cp_req_i.crn == 4'h3
		##1 !(wr && cp_req_i.crn == 4'h3) ##1 (rd &&
		cp_req_i.crn == 4'h3) |=> rd_data_o == $past(cp_req_i.wdata, 3))
		else $error("domain register read wrong");

	fsr_bit8_a: assert property (fault_status_o[8] == 1'b0)
		else $error("fault status bit 8 set");

	fsr_restore_a: assert property (wr && cp_req_i.crn == 4'h5 &&
		!fault_i.valid |=> fault_status_o[7:0] == $past(cp_req_i.wdata[7:0]))
		else $error("fault status restore failed");

	far_capture_a: assert property (fault_i.valid &&
		fault_i.va[31:25] != 7'h00 |=> fault_address_o == $past(fault_i.va))
		else $error("fault address not captured");

	far_restore_a: assert property (wr && cp_req_i.crn == 4'h6 &&
		!fault_i.valid |=> fault_address_o == $past(cp_req_i.wdata))
		else $error("fault address restore failed");

	cache_cmd_a: assert property (cache_inval_all_o |->
		$past(wr) && $past(cp_req_i.crn) == 4'h7 &&
		$past(cp_req_i.coproc_minor_reg_field) == 4'h7 && $past(cp_req_i.op2) == 3'h0)
		else $error("cache invalidate without command");

	tlb_all_a: assert property (wr && cp_req_i.crn == 4'h8 &&
		cp_req_i.op2 == 3'h0 && cp_req_i.coproc_minor_reg_field == 4'h5 |=> tlb_inval_all_o)
		else $error("tlb invalidate missed");

	tlb_one_a: assert property (tlb_inval_single_o |->
		!tlb_inval_all_o && modified_virtual_address_o ==
		$past(cp_req_i.wdata))
		else $error("single tlb invalidate wrong");

	pid_read_a: assert property (rd && cp_req_i.crn == 4'hd &&
		cp_req_i.op2 == 3'h0 |=> rd_data_o[31:25] == relocation_process_id_o)
		else $error("relocation id read wrong");

	pid_write_a: assert property (wr && cp_req_i.crn == 4'hd &&
		cp_req_i.op2 == 3'h0 |=> relocation_process_id_o ==
		$past(cp_req_i.wdata[31:25]))
		else $error("relocation id not loaded");

	trace_store_a: assert property (trace_write_s |=>
		trace_process_id_o == $past(cp_req_i.wdata))
		else $error("trace id not stored");

	trace_notify_a: assert property (trace_write_s ##1
		!cp_valid_i |-> notify_pulse_s)
		else $error("trace notify not a single pulse");

	notify_cause_a: assert property (trace_id_write_notify_o |->
		$past(wr) && $past(cp_req_i.crn) == 4'hd &&
		$past(cp_req_i.op2) == 3'h1)
		else $error("trace notify without write");

	fetch_delay_a: assert property (fetch_i ##1 fetch_i |=>
		fetch_translate_o == $past(mmu_enable_i, 2))
		else $error("fetch translation not delayed");

	fetch_pid_hold_a: assert property (!fetch_i |=>
		$stable(fetch_pid_o))
		else $error("fetch id changed without fetch");

endmodule

// file: rtl/mmu_sysctl_regs.svh
// register numbers, field positions, reset values and command codes
// of the system control register bank; included by the register bank and fault capture files
`ifndef MMU_SYSCTL_REGS_SVH
`define MMU_SYSCTL_REGS_SVH

`define REG_TTB 4'h2
`define REG_DOMAIN 4'h3
`define REG_FAULT_STATUS 4'h5
`define REG_FAULT_ADDRESS 4'h6
`define REG_CACHE_OPS 4'h7
`define REG_TLB_OPS 4'h8
`define REG_PROCESS_ID 4'hd

`define OP2_ZERO 3'h0
`define OP2_ONE 3'h1
`define CRM_C5 4'h5
`define CRM_C6 4'h6
`define CRM_C7 4'h7

`define TTB_LSB 14
`define TTB_W 18
`define FSR_W 9
`define FSR_ZERO_BIT 8
`define PID_LSB 25
`define PID_W 7
`define PID_RESET 7'h00
`define TTB_RESET 18'h0_0000
`define WORD_RESET 32'h0000_0000
`define FSR_RESET 9'h000

// number of instructions already fetched when a control change lands
`define PREFETCH_DEPTH 2

`endif

// file: rtl/mmu_sysctl_pkg.sv
// types shared by the system control register bank and its fault capture
// assumes the core presents one coprocessor transfer per valid cycle
package mmu_sysctl_pkg;

	typedef struct packed {
		logic wr;
		logic [3:0] crn;
		logic [2:0] op2;
		logic [3:0] coproc_minor_reg_field;
		logic [31:0] wdata;
	} cp_req_t;

	typedef struct packed {
		logic valid;
		logic prefetch;
		logic [3:0] domain;
		logic [2:0] ftype;
		logic [31:0] va;
	} fault_t;

endpackage

// file: rtl/fault_capture.sv
// fault status and fault address capture with debugger restore
// assumes fault reports and register writes come from the core clock
`timescale 1ns/1ps
`include "mmu_sysctl_regs.svh"

module fault_capture
	import mmu_sysctl_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire fault_t fault_i,
	input wire logic [6:0] pid_i,
	input wire logic fsr_we_i,
	input wire logic far_we_i,
	input wire logic [31:0] wdata_i,
	output logic [8:0] fault_status_o,
	output logic [31:0] fault_address_o
);

	logic [8:0] fsr_r, fsr_nxt;
	logic [31:0] far_r, far_nxt;
	logic [31:0] modified_virtual_address;

	// low addresses are moved into the current process slot
	always_comb begin
		modified_virtual_address = fault_i.va;
		if (pid_i != `PID_RESET && fault_i.va[31:`PID_LSB] == `PID_RESET) begin
			modified_virtual_address[31:`PID_LSB] = pid_i;
		end
	end

	// a fault in the same cycle as a restore wins: it is newer
	always_comb begin
		fsr_nxt = fsr_r;
		far_nxt = far_r;
		if (fsr_we_i) begin
			fsr_nxt = wdata_i[8:0];
		end
		if (far_we_i) begin
			far_nxt = wdata_i;
		end
		if (fault_i.valid) begin
			fsr_nxt = {1'b0, fault_i.domain, fault_i.ftype, 1'b0};
			far_nxt = modified_virtual_address;
		end
		fsr_nxt[`FSR_ZERO_BIT] = 1'b0;
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fsr_r <= `FSR_RESET;
			far_r <= `WORD_RESET;
		end else begin
			fsr_r <= fsr_nxt;
			far_r <= far_nxt;
		end
	end

	assign fault_status_o = fsr_r;
	assign fault_address_o = far_r;

	fault_latest_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		fault_i.valid |=> fsr_r[7:4] == $past(fault_i.domain) &&
		fsr_r[3:1] == $past(fault_i.ftype))
		else $error("fault status missed the latest fault");

	far_reloc_a: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		fault_i.valid && pid_i != 7'h00 && fault_i.va[31:25] == 7'h00
		|=> far_r[31:25] == $past(pid_i))
		else $error("fault address not relocated");

endmodule

// file: dv/core_model.sv
// model of the core that issues coprocessor register transfers
// assumes one clock shared with the register bank
`timescale 1ns/1ps

module core_model
	import mmu_sysctl_pkg::*;
(
	input wire logic ref_clk_i,
	output logic cp_valid_o,
	output cp_req_t cp_req_o,
	input wire logic rd_valid_i,
	input wire logic [31:0] rd_data_i
);
	initial begin
		cp_valid_o = 1'b0;
		cp_req_o = '0;
	end

	// every transfer counts as issued from a privileged mode
	task automatic xfer(input logic w, input logic [3:0] crn,
		input logic [2:0] op2, input logic [3:0] coproc_minor_reg_field, input logic [31:0] d);
		@(posedge ref_clk_i);
		cp_valid_o <= 1'b1;
		cp_req_o <= '{w, crn, op2, coproc_minor_reg_field, d};
		@(posedge ref_clk_i);
		cp_valid_o <= 1'b0;
		// released bus shows the inverse, never a stale copy
		cp_req_o <= ~cp_req_o;
	endtask

	// minor field always zero; callers never read the command registers
	task automatic rd(input logic [3:0] crn, input logic [2:0] op2,
		output logic [31:0] d);
		xfer(1'b0, crn, op2, 4'h0, 32'h0000_0000);
		#1;
		d = (rd_valid_i === 1'b1) ? rd_data_i : 32'hxxxx_xxxx;
	endtask
	// cache is never enabled here, so translation off is always legal
endmodule

// file: dv/tb_top.sv
// self-checking bench for the system control register bank
// assumes the core model drives transfers and the bench drives the rest
`timescale 1ns/1ps

module tb_top;
	import mmu_sysctl_pkg::*;
	logic ref_clk_i, rst_i, cp_valid_i, mmu_enable_i, fetch_i;
	cp_req_t cp_req_i;
	fault_t fault_i;
	logic [31:0] rd_data_o, d;
	logic rd_valid_o;
	int err_count = 0;
	int cmp_count = 0;

	mmu_system_control_regs DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.cp_valid_i(cp_valid_i), .cp_req_i(cp_req_i), .fault_i(fault_i),
		.mmu_enable_i(mmu_enable_i), .fetch_i(fetch_i),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .table_base_o(),
		.domain_fields_o(), .relocation_process_id_o(),
		.fetch_translate_o(), .fetch_pid_o(), .trace_process_id_o(),
		.trace_id_write_notify_o(), .cache_inval_all_o(),
		.tlb_inval_all_o(), .tlb_inval_single_o(),
		.modified_virtual_address_o(), .fault_status_o(),
		.fault_address_o());
	core_model core (.ref_clk_i(ref_clk_i), .cp_valid_o(cp_valid_i),
		.cp_req_o(cp_req_i), .rd_valid_i(rd_valid_o),
		.rd_data_i(rd_data_o));

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] crn, input logic [2:0] op2,
		input logic [3:0] coproc_minor_reg_field, input logic [31:0] v);
		core.xfer(1'b1, crn, op2, coproc_minor_reg_field, v);
		#1;
	endtask

	task automatic flt(input logic pf, input logic [3:0] dm,
		input logic [2:0] ft, input logic [31:0] va);
		@(posedge ref_clk_i);
		fault_i <= '{1'b1, pf, dm, ft, va};
		@(posedge ref_clk_i);
		fault_i.valid <= 1'b0;
		fault_i.va <= ~va;
		#1;
	endtask

	// n back-to-back fetches with the enable presented at the first edge
	task automatic fetch_n(input int n, input logic en);
		@(posedge ref_clk_i);
		mmu_enable_i <= en;
		fetch_i <= 1'b1;
		repeat (n) @(posedge ref_clk_i);
		fetch_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
	endtask

	task automatic t_ttb_domain();
		wr(4'h2, 3'h0, 4'h0, 32'hFFFF_C000);
		chk(32'(DUT.table_base_o), 32'h0003_FFFF);
		core.rd(4'h2, 3'h0, d);
		chk(d & 32'hFFFF_C000, 32'hFFFF_C000);
		wr(4'h3, 3'h0, 4'h0, 32'hA5C3_1E96);
		chk(DUT.domain_fields_o, 32'hA5C3_1E96);
		core.rd(4'h3, 3'h0, d);
		chk(d, 32'hA5C3_1E96);
	endtask

	task automatic t_fault();
		wr(4'h5, 3'h0, 4'h0, 32'h0000_00FF);
		core.rd(4'h5, 3'h0, d);
		chk(d & 32'h0000_01FF, 32'h0000_00FF);
		flt(1'b0, 4'hA, 3'h5, 32'h0000_1234);
		chk(32'(DUT.fault_status_o), 32'h0000_00AA);
		chk(DUT.fault_address_o, 32'h0000_1234);
		flt(1'b1, 4'h3, 3'h2, 32'h8000_0040);
		chk(32'(DUT.fault_status_o), 32'h0000_0034);
		chk(DUT.fault_address_o, 32'h8000_0040);
		wr(4'h6, 3'h0, 4'h0, 32'hDEAD_BEEF);
		core.rd(4'h6, 3'h0, d);
		chk(d, 32'hDEAD_BEEF);
	endtask

	task automatic t_trace();
		wr(4'hD, 3'h1, 4'h0, 32'h1234_5678);
		chk(DUT.trace_process_id_o, 32'h1234_5678);
		chk(32'(DUT.trace_id_write_notify_o), 32'h0000_0001);
		@(posedge ref_clk_i);
		#1;
		chk(32'(DUT.trace_id_write_notify_o), 32'h0000_0000);
		core.rd(4'hD, 3'h1, d);
		chk(d, 32'h1234_5678);
	endtask

	task automatic t_cmds();
		wr(4'h7, 3'h0, 4'h6, 32'h0000_0000);
		chk(32'(DUT.cache_inval_all_o), 32'h0000_0000);
		wr(4'h7, 3'h0, 4'h7, 32'h0000_0000);
		chk(32'(DUT.cache_inval_all_o), 32'h0000_0001);
		for (int m = 5; m <= 7; m++) begin
			wr(4'h8, 3'h0, 4'(m), 32'h0000_0000);
			chk(32'(DUT.tlb_inval_all_o), 32'h0000_0001);
			wr(4'h8, 3'h1, 4'(m), 32'h00C0_1000 + 32'(m));
			chk(32'(DUT.tlb_inval_single_o), 32'h0000_0001);
			chk(DUT.modified_virtual_address_o,
				32'h00C0_1000 + 32'(m));
		end
	endtask

	task automatic t_reloc();
		wr(4'hD, 3'h0, 4'h0, 32'hAA00_0000);
		chk(32'(DUT.relocation_process_id_o), 32'h0000_0055);
		core.rd(4'hD, 3'h0, d);
		chk(d & 32'hFE00_0000, 32'hAA00_0000);
		flt(1'b0, 4'h1, 3'h1, 32'h0000_1234);
		chk(DUT.fault_address_o, 32'hAA00_1234);
		fetch_n(1, 1'b1);
		chk(32'(DUT.fetch_translate_o), 32'h0000_0000);
		chk(32'(DUT.fetch_pid_o), 32'h0000_0000);
		fetch_n(1, 1'b1);
		chk(32'(DUT.fetch_translate_o), 32'h0000_0001);
		chk(32'(DUT.fetch_pid_o), 32'h0000_0055);
		fetch_n(2, 1'b0);
		chk(32'(DUT.fetch_translate_o), 32'h0000_0000);
		chk(32'(DUT.fetch_pid_o), 32'h0000_0055);
		core.rd(4'h4, 3'h0, d);
		chk(d, 32'h0000_0000);
	endtask

	initial begin
		rst_i = 1'b1;
		mmu_enable_i = 1'b0;
		fetch_i = 1'b0;
		fault_i = '0;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		#1;
		chk(32'(DUT.relocation_process_id_o), 32'h0000_0000);
		t_ttb_domain();
		t_fault();
		t_trace();
		t_cmds();
		t_reloc();
		end_sim();
	end

	// the whole sequence needs under a hundred cycles
	initial begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule
